// [src/alert_drive.v]
// Active-low critical alert pin driver for one set of status bits
`timescale 1ns/100ps
`include "crit_defs.vh"

module alert_drive (
    // Clock and reset
    input  wire                  clk,
    input  wire                  reset,
    // Status bits and their masks
    input  wire [`NUM_CHAN-1:0]  over,
    input  wire [`NUM_CHAN-1:0]  block,
    // Alert pin
    output reg                   alert_n_reg
);

    wire alert_next;

    // A masked channel never reaches the pin
    assign alert_next = |(over & ~block); // R8 R10

    always @(posedge clk) begin
        if (reset) begin
            alert_n_reg <= 1'b1;
        end else begin
            alert_n_reg <= ~alert_next; // R9 R13
        end
    end

endmodule // alert_drive

// [src/crit_defs.vh]
// Offsets, field positions, reset values and widths of the critical-alert status block
`ifndef CRIT_DEFS_VH
`define CRIT_DEFS_VH

// Register command-byte offsets
`define OFS_COMMON_STATUS     8'h02
`define OFS_CRIT_ONE_STATUS   8'h08
`define OFS_CRIT_TWO_STATUS   8'h09
`define OFS_CRIT_THREE_STATUS 8'h0A
`define OFS_MASK_A            8'h0C
`define OFS_MASK_B            8'h0D
`define OFS_MASK_C            8'h0E
`define OFS_LOCAL_LIMIT       8'h40

// Channel bit positions inside each critical status and mask register
`define BIT_LOCAL             0
`define BIT_REM_ONE           1
`define BIT_REM_TWO           2
`define NUM_CHAN              3
`define NUM_OUT               3

// Summary flag positions in the common status register
`define BIT_SUMMARY_A         1
`define BIT_SUMMARY_B         2
`define BIT_SUMMARY_C         3

// Reset values
`define RST_MASK_A            3'h1
`define RST_MASK_B            3'h0
`define RST_MASK_C            3'h7
`define RST_LOCAL_LIMIT       7'h55
`define RST_READ_DATA         8'h00

// Widths of the comparison path (sign bit plus magnitude)
`define CMP_W                 9
`define THR_W                 10

`endif

// [src/critical_temp_status_alert.v]
// Critical over-temperature status registers, masks and three active-low alert pins
//
// Contract
// R1: First status register holds remote two, remote one, local at bits 2..0.
// R2: Second status register uses the same bit placement for its output.
// R3: Third status register uses the same bit placement for its output.
// R4: Bits 7 to 3 of every critical status register read zero.
// R5: Remote bit sets when reading is at or above its limit.
// R6: Bit clears only when reading falls below limit minus common hysteresis.
// R7: Local bits of all three outputs compare against the single local limit.
// R8: An output is active while any unmasked status bit of it is set.
// R9: An output goes inactive once all its status bits have cleared.
// R10: Mask bit one blocks that channel from the output; zero passes it.
// R11: Summary register shows one flag per critical status register, set if any bit.
// R12: Between clear threshold and limit a bit holds; it updates per conversion.
// R13: Alert outputs are active low: low when asserted, high when inactive.
`timescale 1ns/100ps
`include "crit_defs.vh"

module critical_temp_status_alert (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Register access by command byte
    input  wire        reg_rd_en,
    input  wire        reg_wr_en,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wr_data,
    output reg  [7:0]  reg_rd_data,
    // Conversion results from the converter
    input  wire        local_done,
    input  wire [7:0]  local_temp,
    input  wire        rem_one_done,
    input  wire [7:0]  rem_one_temp,
    input  wire        rem_two_done,
    input  wire [7:0]  rem_two_temp,
    // Remote limits and common hysteresis
    input  wire [7:0]  rem_one_limit_a,
    input  wire [7:0]  rem_one_limit_b,
    input  wire [7:0]  rem_one_limit_c,
    input  wire [7:0]  rem_two_limit_a,
    input  wire [7:0]  rem_two_limit_b,
    input  wire [7:0]  rem_two_limit_c,
    input  wire [7:0]  common_hyst,
    // Alert pins
    output wire        crit_alert_out_a_n,
    output wire        crit_alert_out_b_n,
    output wire        crit_alert_out_c_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    function hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Writable registers

    reg  [2:0] mask_a_reg;
    reg  [2:0] mask_b_reg;
    reg  [2:0] mask_c_reg;
    reg  [6:0] local_limit_reg;

    // Writes to read-only or unmapped offsets are dropped without effect
    always @(posedge clk) begin
        if (reset) begin
            mask_a_reg      <= `RST_MASK_A;
            mask_b_reg      <= `RST_MASK_B;
            mask_c_reg      <= `RST_MASK_C;
            local_limit_reg <= `RST_LOCAL_LIMIT;
        end else if (reg_wr_en) begin
            if (hit(reg_addr, `OFS_MASK_A)) begin
                mask_a_reg <= reg_wr_data[2:0]; // R10
            end
            if (hit(reg_addr, `OFS_MASK_B)) begin
                mask_b_reg <= reg_wr_data[2:0]; // R10
            end
            if (hit(reg_addr, `OFS_MASK_C)) begin
                mask_c_reg <= reg_wr_data[2:0]; // R10
            end
            if (hit(reg_addr, `OFS_LOCAL_LIMIT)) begin
                // Top bit is read-only zero, limit spans 0 to 127
                local_limit_reg <= reg_wr_data[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel readings, update strobes and limits

    wire [`NUM_CHAN-1:0]         chan_done;
    wire [`NUM_CHAN*`CMP_W-1:0]  chan_reading;
    wire [`NUM_OUT*`NUM_CHAN*`CMP_W-1:0] limit_flat;
    wire [`CMP_W-1:0]            local_limit_ext;

    assign chan_done[`BIT_LOCAL]   = local_done;
    assign chan_done[`BIT_REM_ONE] = rem_one_done;
    assign chan_done[`BIT_REM_TWO] = rem_two_done;

    // Local reading is two's complement; remote readings are 0 to 255
    assign chan_reading[`BIT_LOCAL*`CMP_W +: `CMP_W]   = {local_temp[7], local_temp};
    assign chan_reading[`BIT_REM_ONE*`CMP_W +: `CMP_W] = {1'b0, rem_one_temp};
    assign chan_reading[`BIT_REM_TWO*`CMP_W +: `CMP_W] = {1'b0, rem_two_temp};

    assign local_limit_ext = {2'b00, local_limit_reg};

    // Output a
    assign limit_flat[(0*`NUM_CHAN+`BIT_LOCAL)*`CMP_W +: `CMP_W]   = local_limit_ext; // R7
    assign limit_flat[(0*`NUM_CHAN+`BIT_REM_ONE)*`CMP_W +: `CMP_W] = {1'b0, rem_one_limit_a};
    assign limit_flat[(0*`NUM_CHAN+`BIT_REM_TWO)*`CMP_W +: `CMP_W] = {1'b0, rem_two_limit_a};
    // Output b
    assign limit_flat[(1*`NUM_CHAN+`BIT_LOCAL)*`CMP_W +: `CMP_W]   = local_limit_ext; // R7
    assign limit_flat[(1*`NUM_CHAN+`BIT_REM_ONE)*`CMP_W +: `CMP_W] = {1'b0, rem_one_limit_b};
    assign limit_flat[(1*`NUM_CHAN+`BIT_REM_TWO)*`CMP_W +: `CMP_W] = {1'b0, rem_two_limit_b};
    // Output c
    assign limit_flat[(2*`NUM_CHAN+`BIT_LOCAL)*`CMP_W +: `CMP_W]   = local_limit_ext; // R7
    assign limit_flat[(2*`NUM_CHAN+`BIT_REM_ONE)*`CMP_W +: `CMP_W] = {1'b0, rem_one_limit_c};
    assign limit_flat[(2*`NUM_CHAN+`BIT_REM_TWO)*`CMP_W +: `CMP_W] = {1'b0, rem_two_limit_c};

    ////////////////////////////////////////////////////////////////////////////////
    // Status bits, one comparator per output and channel

    wire [`NUM_OUT*`NUM_CHAN-1:0] over_flat;

    genvar o;
    genvar c;
    generate
        for (o = 0; o < `NUM_OUT; o = o + 1) begin : g_out
            for (c = 0; c < `NUM_CHAN; c = c + 1) begin : g_chan
                hyst_compare u_cmp (
                    .clk      (clk),
                    .reset    (reset),
                    .update   (chan_done[c]),
                    .reading  (chan_reading[c*`CMP_W +: `CMP_W]),
                    .limit    (limit_flat[(o*`NUM_CHAN+c)*`CMP_W +: `CMP_W]),
                    .hyst     (common_hyst),
                    .over_reg (over_flat[o*`NUM_CHAN+c])
                ); // R5 R6 R12
            end
        end
    endgenerate

    wire [2:0] over_a;
    wire [2:0] over_b;
    wire [2:0] over_c;

    assign over_a = over_flat[0*`NUM_CHAN +: `NUM_CHAN];
    assign over_b = over_flat[1*`NUM_CHAN +: `NUM_CHAN];
    assign over_c = over_flat[2*`NUM_CHAN +: `NUM_CHAN];

    ////////////////////////////////////////////////////////////////////////////////
    // Alert pins

    alert_drive u_alert_a (
        .clk         (clk),
        .reset       (reset),
        .over        (over_a),
        .block       (mask_a_reg),
        .alert_n_reg (crit_alert_out_a_n)
    ); // R8 R9 R13

    alert_drive u_alert_b (
        .clk         (clk),
        .reset       (reset),
        .over        (over_b),
        .block       (mask_b_reg),
        .alert_n_reg (crit_alert_out_b_n)
    ); // R8 R9 R13

    alert_drive u_alert_c (
        .clk         (clk),
        .reset       (reset),
        .over        (over_c),
        .block       (mask_c_reg),
        .alert_n_reg (crit_alert_out_c_n)
    ); // R8 R9 R13

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back

    wire [7:0] crit_one_status;
    wire [7:0] crit_two_status;
    wire [7:0] crit_three_status;
    wire [7:0] common_status;
    wire       summary_flag_a;
    wire       summary_flag_b;
    wire       summary_flag_c;
    reg  [7:0] rd_next;

    assign crit_one_status   = {5'h00, over_a}; // R1 R4
    assign crit_two_status   = {5'h00, over_b}; // R2 R4
    assign crit_three_status = {5'h00, over_c}; // R3 R4

    // Flags follow the raw status, not the masked alert
    assign summary_flag_a = |over_a; // R11
    assign summary_flag_b = |over_b; // R11
    assign summary_flag_c = |over_c; // R11

    // Busy, not-ready and diode-fault flag belong to other blocks and read zero here
    assign common_status = {4'h0, summary_flag_c, summary_flag_b, summary_flag_a, 1'b0}; // R11

    always @* begin
        rd_next = `RST_READ_DATA;
        if (hit(reg_addr, `OFS_COMMON_STATUS)) begin
            rd_next = common_status;
        end else if (hit(reg_addr, `OFS_CRIT_ONE_STATUS)) begin
            rd_next = crit_one_status;
        end else if (hit(reg_addr, `OFS_CRIT_TWO_STATUS)) begin
            rd_next = crit_two_status;
        end else if (hit(reg_addr, `OFS_CRIT_THREE_STATUS)) begin
            rd_next = crit_three_status;
        end else if (hit(reg_addr, `OFS_MASK_A)) begin
            rd_next = {5'h00, mask_a_reg};
        end else if (hit(reg_addr, `OFS_MASK_B)) begin
            rd_next = {5'h00, mask_b_reg};
        end else if (hit(reg_addr, `OFS_MASK_C)) begin
            rd_next = {5'h00, mask_c_reg};
        end else if (hit(reg_addr, `OFS_LOCAL_LIMIT)) begin
            rd_next = {1'b0, local_limit_reg};
        end
    end

    // Read data is held until the next read so a slow serial engine can shift it out
    always @(posedge clk) begin
        if (reset) begin
            reg_rd_data <= `RST_READ_DATA;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_next;
        end
    end

endmodule // critical_temp_status_alert

// [src/hyst_compare.v]
// One channel status bit: set at or above the limit, cleared below limit minus hysteresis
`timescale 1ns/100ps
`include "crit_defs.vh"

module hyst_compare (
    // Clock and reset
    input  wire                clk,
    input  wire                reset,
    // Conversion result
    input  wire                update,
    input  wire [`CMP_W-1:0]   reading,
    input  wire [`CMP_W-1:0]   limit,
    input  wire [7:0]          hyst,
    // Status bit
    output reg                 over_reg
);

    wire signed [`THR_W-1:0] reading_ext;
    wire signed [`THR_W-1:0] limit_ext;
    wire signed [`THR_W-1:0] clear_thr;
    reg                      over_next;

    assign reading_ext = {reading[`CMP_W-1], reading};
    assign limit_ext   = {limit[`CMP_W-1], limit};
    // Ten bits keep limit minus a full-scale hysteresis from wrapping
    assign clear_thr   = limit_ext - $signed({2'b00, hyst});

    always @* begin
        over_next = over_reg;
        if (update) begin
            if (reading_ext >= limit_ext) begin
                over_next = 1'b1; // R5
            end else if (reading_ext < clear_thr) begin
                over_next = 1'b0; // R6
            end
            // Inside the hysteresis band the bit holds R12
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            over_reg <= 1'b0;
        end else begin
            over_reg <= over_next; // R12
        end
    end

endmodule // hyst_compare

// [test/crit_alert_chk.sv]
// Port assertions for the critical alert status block
`timescale 1ns/100ps
`include "crit_defs.vh"
module crit_alert_chk (
    // Clock and reset
    input wire       clk,
    input wire       reset,
    // Register port
    input wire       reg_rd_en,
    input wire       reg_wr_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wr_data,
    input wire [7:0] reg_rd_data,
    // Conversions and limits
    input wire       local_done,
    input wire [7:0] local_temp,
    input wire       rem_one_done,
    input wire [7:0] rem_one_temp,
    input wire       rem_two_done,
    input wire [7:0] rem_two_temp,
    input wire [7:0] rem_one_limit_a,
    input wire [7:0] rem_two_limit_b,
    // Alert pins
    input wire       crit_alert_out_a_n,
    input wire       crit_alert_out_b_n,
    input wire       crit_alert_out_c_n
);
default clocking cb @(posedge clk); endclocking
default disable iff (reset);
////////////////////////////////////////////////////////////////
// Shadow of masks and local limit, so alert timing can be judged
reg [2:0] mask_a_reg;
reg [2:0] mask_b_reg;
reg [2:0] mask_c_reg;
reg [6:0] lim_reg;
always @(posedge clk) begin
    if (reset) begin
        mask_a_reg <= `RST_MASK_A;
        mask_b_reg <= `RST_MASK_B;
        mask_c_reg <= `RST_MASK_C;
        lim_reg    <= `RST_LOCAL_LIMIT;
    end else if (reg_wr_en) begin
        if (reg_addr == 8'h0C) mask_a_reg <= reg_wr_data[2:0];
        if (reg_addr == 8'h0D) mask_b_reg <= reg_wr_data[2:0];
        if (reg_addr == 8'h0E) mask_c_reg <= reg_wr_data[2:0];
        if (reg_addr == 8'h40) lim_reg <= reg_wr_data[6:0];
    end
end
////////////////////////////////////////////////////////////////
sequence s_low_a; ##1 !crit_alert_out_a_n; endsequence
sequence s_low_b; ##1 !crit_alert_out_b_n; endsequence
sequence s_low_c; ##1 !crit_alert_out_c_n; endsequence
a_reserved_zero: assert property (reg_rd_en && reg_addr inside {8'h08, 8'h09, 8'h0A}
    |=> reg_rd_data[7:3] == 5'h00) else $error("status upper bits not zero");
a_read_stands: assert property (!reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data moved without a read");
a_summary_form: assert property (reg_rd_en && reg_addr == 8'h02
    |=> reg_rd_data[7:4] == 4'h0 && !reg_rd_data[0]) else $error("summary layout wrong");
a_rem_one_a: assert property (rem_one_done && rem_one_temp >= rem_one_limit_a
    |=> (!mask_a_reg[1] |-> s_low_a)) else $error("alert a missed remote one");
a_rem_two_b: assert property (rem_two_done && rem_two_temp >= rem_two_limit_b
    |=> (!mask_b_reg[2] |-> s_low_b)) else $error("alert b missed remote two");
a_local_c: assert property (local_done && $signed(local_temp) >= $signed({1'b0, lim_reg})
    |=> (!mask_c_reg[0] |-> s_low_c)) else $error("alert c missed local");
a_mask_blocks_a: assert property (&mask_a_reg |=> crit_alert_out_a_n)
    else $error("fully masked alert a active");
a_fall_cause: assert property ($fell(crit_alert_out_c_n) |-> !$past(&mask_c_reg))
    else $error("alert c fell while fully masked");
endmodule // crit_alert_chk
bind critical_temp_status_alert crit_alert_chk crit_alert_chk_inst (.*);

// [test/tb_critical_temp_status_alert.sv]
// Self-checking bench for the critical alert status block
`timescale 1ns/100ps
module tb_critical_temp_status_alert;
reg       clk = 0, reset = 1, reg_rd_en = 0, reg_wr_en = 0;
reg [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00;
reg       local_done = 0, rem_one_done = 0, rem_two_done = 0;
reg [7:0] local_temp = 8'h00, rem_one_temp = 8'h00, rem_two_temp = 8'h00;
reg [7:0] common_hyst = 8'h0A, rem_one_limit_a = 8'h64;
wire [7:0] reg_rd_data;
wire       a_n, b_n, c_n;
wire [2:0] tripped;
integer    miscompares = 0, n_compared = 0;
critical_temp_status_alert critical_temp_status_alert_inst (
    .clk(clk), .reset(reset), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .local_done(local_done), .local_temp(local_temp), .rem_one_done(rem_one_done),
    .rem_one_temp(rem_one_temp), .rem_two_done(rem_two_done), .rem_two_temp(rem_two_temp),
    .rem_one_limit_a(rem_one_limit_a), .rem_one_limit_b(8'h78), .rem_one_limit_c(8'h50),
    .rem_two_limit_a(8'h96), .rem_two_limit_b(8'h5A), .rem_two_limit_c(8'hC8),
    .common_hyst(common_hyst), .crit_alert_out_a_n(a_n), .crit_alert_out_b_n(b_n),
    .crit_alert_out_c_n(c_n));
thermal_shutdown_model thermal_shutdown_model_inst (.clk(clk), .reset(reset),
    .alert_a_n(a_n), .alert_b_n(b_n), .alert_c_n(c_n), .tripped_reg(tripped));
////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input [7:0] exp, input [7:0] got);
    n_compared++;
    if (got !== exp) begin
        miscompares++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic rd(input [7:0] a, input [7:0] exp);
    @(negedge clk);
    reg_rd_en = 1;
    reg_addr = a;
    @(negedge clk);
    reg_rd_en = 0;
    chk($sformatf("reg %h", a), exp, reg_rd_data);
endtask
task automatic wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    reg_wr_en = 1;
    reg_addr = a;
    reg_wr_data = d;
    @(negedge clk);
    reg_wr_en = 0;
endtask
// Pulses one channel's done; returns once the alert pins have settled
task automatic conv(input int ch, input [7:0] t);
    @(negedge clk);
    {local_temp, rem_one_temp, rem_two_temp} = {t, t, t};
    {rem_two_done, rem_one_done, local_done} = 3'h1 << ch;
    @(negedge clk);
    {rem_two_done, rem_one_done, local_done} = 3'h0;
    @(negedge clk);
endtask
task automatic al(input [2:0] e);
    chk("alerts cba", {5'h00, e}, {5'h00, c_n, b_n, a_n});
endtask
////////////////////////////////////////////////////////////////
task t_reset;
    al(3'h7);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h0C, 8'h01);
    rd(8'h0D, 8'h00);
    rd(8'h0E, 8'h07);
    rd(8'h40, 8'h55);
    rd(8'h33, 8'h00);
endtask
task t_remote_one;
    conv(1, 8'd100);
    al(3'h6);
    rd(8'h08, 8'h02);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h02);
    rd(8'h02, 8'h0A);
    conv(1, 8'd91);
    rd(8'h08, 8'h02);
    conv(1, 8'd89);
    rd(8'h08, 8'h00);
    al(3'h7);
    rd(8'h0A, 8'h02);
endtask
task t_local;
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h7F);
    wr(8'h40, 8'h50);
    conv(0, 8'd80);
    rd(8'h08, 8'h01);
    rd(8'h09, 8'h01);
    rd(8'h0A, 8'h03);
    al(3'h5);
    wr(8'h0C, 8'h00);
    @(negedge clk);
    al(3'h4);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h01);
    conv(0, 8'hF0);
    rd(8'h09, 8'h00);
    al(3'h7);
endtask
task t_remote_two;
    conv(2, 8'd150);
    rd(8'h08, 8'h04);
    rd(8'h09, 8'h04);
    rd(8'h0A, 8'h02);
    al(3'h4);
    wr(8'h0E, 8'h00);
    @(negedge clk);
    al(3'h0);
    rd(8'h02, 8'h0E);
    chk("tripped", 8'h07, {5'h00, tripped});
endtask
// Wider hysteresis and a lower remote limit: band edges move with the inputs
task t_limits_hyst;
    wr(8'h0C, 8'h07);
    @(negedge clk);
    al(3'h1);
    @(negedge clk);
    common_hyst = 8'h20;
    rem_one_limit_a = 8'h46;
    conv(1, 8'd60);
    rd(8'h08, 8'h04);
    rd(8'h0A, 8'h02);
    conv(1, 8'd72);
    rd(8'h08, 8'h06);
    conv(1, 8'd40);
    rd(8'h08, 8'h06);
    rd(8'h0A, 8'h00);
    conv(1, 8'd37);
    rd(8'h08, 8'h04);
    al(3'h5);
    conv(0, 8'd85);
    rd(8'h0A, 8'h01);
    al(3'h1);
endtask
// Reset in mid-run must drop every status bit and restore mask a and the local limit
task t_mid_reset;
    @(negedge clk);
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    al(3'h7);
    rd(8'h08, 8'h00);
    rd(8'h0A, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h0C, 8'h01);
    rd(8'h40, 8'h55);
    chk("tripped", 8'h00, {5'h00, tripped});
endtask
////////////////////////////////////////////////////////////////
task give_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
initial begin
    forever #4 clk = ~clk;
end
initial begin
    #100000;
    miscompares++;
    give_verdict;
end
initial begin
    repeat (4) @(negedge clk);
    reset = 0;
    t_reset;
    t_remote_one;
    t_local;
    t_remote_two;
    t_limits_hyst;
    t_mid_reset;
    give_verdict;
end
endmodule // tb_critical_temp_status_alert

// [test/thermal_shutdown_model.sv]
// Shutdown logic model that latches every alert pin it has seen active
`timescale 1ns/100ps
module thermal_shutdown_model (
    // Clock and reset
    input wire       clk,
    input wire       reset,
    // Alert pins, active low
    input wire       alert_a_n,
    input wire       alert_b_n,
    input wire       alert_c_n,
    // Outputs seen active since reset
    output reg [2:0] tripped_reg
);
always @(posedge clk) begin
    if (reset) begin
        tripped_reg <= 3'h0;
    end else begin
        tripped_reg <= tripped_reg | ~{alert_c_n, alert_b_n, alert_a_n};
    end
end
endmodule // thermal_shutdown_model
